// ### design/nfb_notch_bank.sv
// Purpose: Three-stage notch filter bank on the torque command, with
//          adaptive, swept and online resonance identification.
// Assumes: TQ_IN_VALID marks one sample at FS_HZ; VIB_IN is the
//          vibration feedback sampled with it.
// Notes:   Each stage is a state-variable notch; settings act on the
//          next sample.
// Operation
// - Stages one and two filter only while their enable bit is set.
// - Stage three is active from its frequency setting alone.
// - A centre frequency at the top value bypasses that stage.
// - Frequencies hold 50 to 5000 Hz, reset to bypass, enables clear.
// - Width is bandwidth over centre in hundredths, default 70.
// - Depth zero fully rejects the centre; more depth passes more.
// - Depth is output over input in thousandths, default zero.
// - Self-tune with both adaptive selects writes stage one itself.
// - The sweep reports the frequency of highest amplitude.
// - The sweep excites with the configured torque amplitude.
// - Online identification lasts ten seconds and shows detections.
// - Confirming writes the result into a free stage and enables it.
// - Detection uses a sensitivity and a level; lower level detects more.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module nfb_notch_bank #(
  parameter int unsigned IDENT_CYCLES = nfb_pkg::IDENT_CYCLES
) (
  input  wire logic        CLK,          // 20 MHz clock
  input  wire logic        NRST,         // Synchronous reset, active low
  input  wire logic        CE,           // Clock enable, freezes all state
  input  wire logic [4:0]  ADDR,         // Register address
  input  wire logic [15:0] WDATA,        // Write data
  input  wire logic        WR,           // Write strobe
  input  wire logic        RD,           // Read strobe
  output logic      [15:0] RDATA,        // Read data, cycle after RD
  input  wire logic        SERVO_ON,     // Servo enabled
  input  wire logic [15:0] TQ_IN,        // Torque command sample
  input  wire logic        TQ_IN_VALID,  // Sample strobe
  input  wire logic [15:0] VIB_IN,       // Vibration feedback sample
  output logic      [15:0] TQ_OUT,       // Filtered torque or excitation
  output logic             TQ_OUT_VALID  // Output sample strobe
);
  nfb_pkg::nfb_state_t s_q;
  nfb_pkg::nfb_state_t s_d;

  function automatic logic [15:0] clampv(input logic [15:0] v,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic signed [31:0] mulq(
      input logic signed [31:0] a, input logic [19:0] c);
    logic signed [52:0] p;
    p = a * $signed({1'b0, c});
    return p[47:16];
  endfunction

  function automatic nfb_pkg::nfb_state_t rst_state();
    nfb_pkg::nfb_state_t r;
    r = '0;
    for (int i = 0; i < 3; i++) begin
      r.stg[i].freq  = nfb_pkg::FREQ_BYP;
      r.stg[i].width = nfb_pkg::WID_RST;
      r.stg[i].depth = nfb_pkg::DEP_RST;
    end
    r.amp   = nfb_pkg::AMP_RST;
    r.sens  = nfb_pkg::SENS_RST;
    r.level = nfb_pkg::LVL_RST;
    r.mode  = nfb_pkg::ST_IDLE;
    return r;
  endfunction

  always_comb begin
    logic signed [31:0] x;
    logic signed [31:0] lo_n;
    logic signed [31:0] hi;
    logic signed [31:0] qb;
    logic [31:0]        t;
    logic [19:0]        kf;
    logic [19:0]        kq;
    logic [19:0]        kg;
    logic [15:0]        va;
    logic [4:0]         ra;
    logic               act;
    logic               idle;
    x    = '0;
    lo_n = '0;
    hi   = '0;
    qb   = '0;
    t    = '0;
    kf   = '0;
    kq   = '0;
    kg   = '0;
    act  = 1'b0;
    va   = VIB_IN[15] ? 16'(-VIB_IN) : VIB_IN;
    ra   = ADDR - nfb_pkg::A_F1;
    idle = (s_q.mode == nfb_pkg::ST_IDLE);
    s_d  = s_q;
    s_d.out_vld = 1'b0;
    s_d.det_new = 1'b0;

    // Register read, data only in the cycle after the strobe
    s_d.rdata = '0;
    if (RD) begin
      if (ADDR == nfb_pkg::A_CTRL) begin
        s_d.rdata = {11'h000, s_q.ctrl};
      end else if (ADDR >= nfb_pkg::A_F1 && ADDR < nfb_pkg::A_SWAMP) begin
        case (ra % 5'h03)
          5'h00:   s_d.rdata = s_q.stg[ra / 5'h03].freq;
          5'h01:   s_d.rdata = s_q.stg[ra / 5'h03].width;
          default: s_d.rdata = s_q.stg[ra / 5'h03].depth;
        endcase
      end else begin
        case (ADDR)
          nfb_pkg::A_SWAMP:  s_d.rdata = s_q.amp;
          nfb_pkg::A_SENS:   s_d.rdata = s_q.sens;
          nfb_pkg::A_LEVEL:  s_d.rdata = s_q.level;
          nfb_pkg::A_STATUS: s_d.rdata = {12'h000, s_q.res_ok,
                                          s_q.no_free, 2'(s_q.mode)};
          nfb_pkg::A_MON1:   s_d.rdata = s_q.det_f;
          nfb_pkg::A_MON2:   s_d.rdata = s_q.mon2;
          default:           s_d.rdata = '0;
        endcase
      end
    end

    // Register write; out-of-range values are clamped, not refused
    if (WR) begin
      if (ADDR == nfb_pkg::A_CTRL) begin
        s_d.ctrl = WDATA[4:0];
      end else if (ADDR >= nfb_pkg::A_F1 && ADDR < nfb_pkg::A_SWAMP) begin
        case (ra % 5'h03)
          5'h00: s_d.stg[ra / 5'h03].freq = clampv(WDATA,
                   nfb_pkg::FREQ_MIN, nfb_pkg::FREQ_BYP);
          5'h01: s_d.stg[ra / 5'h03].width = clampv(WDATA,
                   nfb_pkg::WID_MIN, nfb_pkg::WID_MAX);
          default: s_d.stg[ra / 5'h03].depth = clampv(WDATA,
                     16'h0000, nfb_pkg::DEP_MAX);
        endcase
      end else begin
        case (ADDR)
          nfb_pkg::A_SWAMP: s_d.amp = clampv(WDATA,
                              nfb_pkg::AMP_MIN, nfb_pkg::AMP_MAX);
          nfb_pkg::A_SENS:  s_d.sens = clampv(WDATA,
                              nfb_pkg::SENS_MIN, nfb_pkg::SENS_MAX);
          nfb_pkg::A_LEVEL: s_d.level = clampv(WDATA,
                              16'h0000, nfb_pkg::LVL_MAX);
          default: ;
        endcase
      end
    end

    if (TQ_IN_VALID) begin
      // Stages in series, each reading last cycle's settings
      x = {{8{TQ_IN[15]}}, TQ_IN, 8'h00};
      for (int i = 0; i < 3; i++) begin
        act = (s_q.stg[i].freq != nfb_pkg::FREQ_BYP) &&
              (i == 2 || s_q.ctrl[i]);
        if (act) begin
          t    = s_q.stg[i].freq * nfb_pkg::KF;
          kf   = t[22:3];
          t    = s_q.stg[i].width * nfb_pkg::KQ;
          kq   = t[19:0];
          t    = (nfb_pkg::DEP_MAX - s_q.stg[i].depth) * nfb_pkg::KG;
          kg   = t[26:7];
          lo_n = s_q.stg[i].low + mulq(s_q.stg[i].band, kf);
          qb   = mulq(s_q.stg[i].band, kq);
          hi   = x - lo_n - qb;
          s_d.stg[i].low  = lo_n;
          s_d.stg[i].band = s_q.stg[i].band + mulq(hi, kf);
          // Centre gain equals depth fraction
          x = x - mulq(qb, kg);
        end else begin
          // Idle stages restart clean when enabled again
          s_d.stg[i].low  = '0;
          s_d.stg[i].band = '0;
        end
      end
      if (x > 32'sh007fff00) begin
        s_d.tq_out = 16'h7fff;
      end else if (x < -32'sh00800000) begin
        s_d.tq_out = 16'h8000;
      end else begin
        s_d.tq_out = x[23:8];
      end
      s_d.out_vld = 1'b1;

      // Crossing counter with hysteresis of sens, peak above level
      if (va > s_q.cyc_pk) begin
        s_d.cyc_pk = va;
      end
      if (!s_q.pos && $signed(VIB_IN) > $signed(s_q.sens)) begin
        s_d.pos    = 1'b1;
        s_d.cyc_pk = '0;
        if (s_q.cyc_pk > s_q.level && s_q.cnt != 16'hffff) begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end else if (s_q.pos && $signed(VIB_IN) < -$signed(s_q.sens)) begin
        s_d.pos = 1'b0;
      end
      s_d.win = s_q.win + 16'h0001;
      if (s_q.win == nfb_pkg::DET_WIN - 16'h0001) begin
        t           = s_q.cnt * nfb_pkg::DET_SCALE;
        s_d.win     = '0;
        s_d.cnt     = '0;
        s_d.det_f   = t[15:0];
        s_d.det_new = (t >= 32'(nfb_pkg::FREQ_MIN)) &&
                      (t < 32'(nfb_pkg::FREQ_BYP));
      end
    end

    case (s_q.mode)
      nfb_pkg::ST_IDLE: begin
        if (WR && ADDR == nfb_pkg::A_CMD) begin
          if (WDATA[nfb_pkg::K_SWEEP] && !SERVO_ON) begin
            s_d.mode    = nfb_pkg::ST_SWEEP;
            s_d.sw_f    = nfb_pkg::FREQ_MIN;
            s_d.dwell   = '0;
            s_d.pk      = '0;
            s_d.best_pk = '0;
            s_d.best_f  = nfb_pkg::FREQ_MIN;
            s_d.phase   = '0;
            s_d.res_ok  = 1'b0;
          end else if (WDATA[nfb_pkg::K_IDENT]) begin
            s_d.mode   = nfb_pkg::ST_IDENT;
            s_d.tmr    = '0;
            s_d.res_ok = 1'b0;
          end
        end
      end
      nfb_pkg::ST_SWEEP: begin
        if (TQ_IN_VALID) begin
          t         = s_q.sw_f * nfb_pkg::KP;
          s_d.phase = s_q.phase + t[23:8];
          // Square excitation replaces the command
          s_d.tq_out = s_q.phase[15] ? s_q.amp : 16'(-s_q.amp);
          s_d.pk    = (va > s_q.pk) ? va : s_q.pk;
          s_d.dwell = s_q.dwell + 16'h0001;
          if (s_q.dwell == nfb_pkg::SWEEP_DWELL - 16'h0001) begin
            s_d.dwell = '0;
            s_d.pk    = '0;
            // Largest response wins, resonance or not
            if (s_q.pk > s_q.best_pk) begin
              s_d.best_pk = s_q.pk;
              s_d.best_f  = s_q.sw_f;
            end
            s_d.sw_f = s_q.sw_f + nfb_pkg::SWEEP_STEP;
            if (s_q.sw_f + nfb_pkg::SWEEP_STEP >= nfb_pkg::FREQ_BYP) begin
              s_d.mode   = nfb_pkg::ST_IDLE;
              s_d.mon2   = (s_q.pk > s_q.best_pk) ? s_q.sw_f : s_q.best_f;
              s_d.res    = s_d.mon2;
              s_d.res_ok = 1'b1;
            end
          end
        end
        // Enabling the servo mid-sweep stops the excitation at once
        if (SERVO_ON || (WR && ADDR == nfb_pkg::A_CMD &&
                         WDATA[nfb_pkg::K_ABORT])) begin
          s_d.mode = nfb_pkg::ST_IDLE;
        end
      end
      nfb_pkg::ST_IDENT: begin
        s_d.tmr = s_q.tmr + 32'h0000_0001;
        if (s_q.det_new) begin
          s_d.res    = s_q.det_f;
          s_d.res_ok = 1'b1;
        end
        if (s_q.tmr == IDENT_CYCLES - 1 ||
            (WR && ADDR == nfb_pkg::A_CMD && WDATA[nfb_pkg::K_ABORT])) begin
          s_d.mode = nfb_pkg::ST_IDLE;
        end
      end
      default: s_d.mode = nfb_pkg::ST_IDLE;
    endcase

    // Hardware settings land after software writes, so they win
    if (idle && WR && ADDR == nfb_pkg::A_CMD && WDATA[nfb_pkg::K_CONF]
        && s_q.res_ok) begin
      s_d.no_free = 1'b0;
      if (!s_q.ctrl[0]) begin
        s_d.stg[0].freq = s_q.res;
        s_d.ctrl[0]     = 1'b1;
      end else if (!s_q.ctrl[1]) begin
        s_d.stg[1].freq = s_q.res;
        s_d.ctrl[1]     = 1'b1;
      end else begin
        s_d.no_free = 1'b1;
      end
    end
    if (idle && s_q.det_new && s_q.ctrl[nfb_pkg::C_TUNE] &&
        s_q.ctrl[nfb_pkg::C_SELA] && s_q.ctrl[nfb_pkg::C_SELB]) begin
      s_d.stg[0].freq = s_q.det_f;
      s_d.ctrl[0]     = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s_q <= rst_state();
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign RDATA        = s_q.rdata;
  assign TQ_OUT       = s_q.tq_out;
  assign TQ_OUT_VALID = s_q.out_vld;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  logic all_off;
  assign all_off = !s_q.ctrl[0] && !s_q.ctrl[1] &&
                   s_q.stg[2].freq == nfb_pkg::FREQ_BYP &&
                   s_q.mode == nfb_pkg::ST_IDLE;

  AST_BYPASS: assert property (CE && TQ_IN_VALID && all_off |=>
    TQ_OUT_VALID && TQ_OUT == $past(TQ_IN))
    else $error("bypassed bank altered the sample");
  AST_DISABLED_IDLE: assert property (CE && TQ_IN_VALID &&
    !s_q.ctrl[0] |=> s_q.stg[0].low == 0 && s_q.stg[0].band == 0)
    else $error("disabled stage one holds state");
  AST_THIRD_RUNS: assert property (CE && TQ_IN_VALID &&
    s_q.stg[2].freq != nfb_pkg::FREQ_BYP && s_q.stg[2].band != 0
    && !s_q.ctrl[0] && !s_q.ctrl[1] |=> s_q.stg[2].low != $past(
    s_q.stg[2].low) || s_q.stg[2].band != $past(s_q.stg[2].band))
    else $error("stage three did not run");
  AST_RST_VAL: assert property ($rose(NRST) |->
    s_q.stg[1].freq == nfb_pkg::FREQ_BYP && s_q.ctrl == 0 &&
    s_q.stg[1].width == nfb_pkg::WID_RST && s_q.stg[1].depth == 0)
    else $error("wrong reset settings");
  AST_EXCITE: assert property (s_q.mode == nfb_pkg::ST_SWEEP &&
    CE && TQ_IN_VALID |=> TQ_OUT == $past(s_q.amp) ||
    TQ_OUT == 16'(-$past(s_q.amp)))
    else $error("excitation amplitude wrong");
  AST_IDENT_LEN: assert property (s_q.mode == nfb_pkg::ST_IDENT
    |-> s_q.tmr < IDENT_CYCLES)
    else $error("identification ran too long");
  AST_CONFIRM: assert property (CE && s_q.mode == nfb_pkg::ST_IDLE
    && WR && ADDR == nfb_pkg::A_CMD && WDATA[nfb_pkg::K_CONF] &&
    s_q.res_ok && !s_q.ctrl[0] |=> s_q.ctrl[0] &&
    s_q.stg[0].freq == $past(s_q.res))
    else $error("confirm did not fill stage one");
  AST_ADAPT: assert property (CE && s_q.det_new && !WR &&
    s_q.mode == nfb_pkg::ST_IDLE && s_q.ctrl[4:2] == 3'h7 |=>
    s_q.ctrl[0] && s_q.stg[0].freq == $past(s_q.det_f))
    else $error("adaptive result not written");
  AST_LIVE_SET: assert property (CE && WR && ADDR == nfb_pkg::A_F1
    && WDATA == nfb_pkg::FREQ_BYP && !s_q.det_new && !s_q.res_ok
    |=> s_q.stg[0].freq == nfb_pkg::FREQ_BYP)
    else $error("frequency write lost");
  AST_SWEEP_END: assert property (s_q.mode == nfb_pkg::ST_SWEEP
    ##1 s_q.mode == nfb_pkg::ST_IDLE && s_q.res_ok |->
    s_q.res == s_q.mon2)
    else $error("sweep result not reported");

  COV_SWEEP: cover property (s_q.mode == nfb_pkg::ST_SWEEP ##1
    s_q.mode == nfb_pkg::ST_IDLE && s_q.res_ok);
  COV_IDENT: cover property (s_q.mode == nfb_pkg::ST_IDENT &&
    s_q.det_new);
  COV_NOFREE: cover property ($rose(s_q.no_free));
endmodule

// ### design/nfb_pkg.sv
// Purpose: Shared constants and types for the notch filter bank.
// Assumes: 20 MHz clock, torque samples at FS_HZ.
// Notes:   All settings but the 5-bit control word are 16-bit words, clamped on write.
package nfb_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned IDENT_TIME_S = 10;
  localparam int unsigned IDENT_CYCLES = IDENT_TIME_S * CLK_HZ;
  localparam int unsigned FS_HZ        = 20_000;
  localparam logic [15:0] DET_WIN      = 16'(FS_HZ / 10);
  localparam logic [15:0] DET_SCALE    = 16'h000a;
  localparam logic [15:0] SWEEP_DWELL  = 16'h03e8;
  localparam logic [15:0] SWEEP_STEP   = 16'h0032;
  // Register addresses
  localparam logic [4:0] A_CTRL   = 5'h00;
  localparam logic [4:0] A_F1     = 5'h01;
  localparam logic [4:0] A_SWAMP  = 5'h0a;
  localparam logic [4:0] A_SENS   = 5'h0b;
  localparam logic [4:0] A_LEVEL  = 5'h0c;
  localparam logic [4:0] A_CMD    = 5'h0d;
  localparam logic [4:0] A_STATUS = 5'h0e;
  localparam logic [4:0] A_MON1   = 5'h0f;
  localparam logic [4:0] A_MON2   = 5'h10;
  // Control and command bit positions
  localparam int unsigned C_SELA  = 2;
  localparam int unsigned C_SELB  = 3;
  localparam int unsigned C_TUNE  = 4;
  localparam int unsigned K_SWEEP = 0;
  localparam int unsigned K_IDENT = 1;
  localparam int unsigned K_CONF  = 2;
  localparam int unsigned K_ABORT = 3;
  // Ranges and reset values
  localparam logic [15:0] FREQ_MIN = 16'h0032;
  localparam logic [15:0] FREQ_BYP = 16'h1388;
  localparam logic [15:0] WID_MIN  = 16'h0032;
  localparam logic [15:0] WID_MAX  = 16'h03e8;
  localparam logic [15:0] WID_RST  = 16'h0046;
  localparam logic [15:0] DEP_MAX  = 16'h03e8;
  localparam logic [15:0] DEP_RST  = 16'h0000;
  localparam logic [15:0] AMP_MIN  = 16'h0001;
  localparam logic [15:0] AMP_MAX  = 16'h012c;
  localparam logic [15:0] AMP_RST  = 16'h0064;
  localparam logic [15:0] SENS_MIN = 16'h0032;
  localparam logic [15:0] SENS_MAX = 16'h01f4;
  localparam logic [15:0] SENS_RST = 16'h0064;
  localparam logic [15:0] LVL_MAX  = 16'h1388;
  localparam logic [15:0] LVL_RST  = 16'h03e8;
  // Fixed-point coefficient scales (Q16 after the shift)
  localparam logic [15:0] KF = 16'h00a5;
  localparam logic [15:0] KQ = 16'h028f;
  localparam logic [15:0] KG = 16'h20c5;
  localparam logic [15:0] KP = 16'h0347;

  typedef enum logic [1:0] {ST_IDLE, ST_SWEEP, ST_IDENT} nfb_mode_t;

  typedef struct packed {
    logic [15:0]        freq;
    logic [15:0]        width;
    logic [15:0]        depth;
    logic signed [31:0] low;
    logic signed [31:0] band;
  } nfb_stage_t;

  typedef struct packed {
    nfb_stage_t [2:0] stg;
    logic [4:0]       ctrl;
    logic [15:0]      amp;
    logic [15:0]      sens;
    logic [15:0]      level;
    nfb_mode_t        mode;
    logic [15:0]      tq_out;
    logic             out_vld;
    logic [15:0]      rdata;
    logic [31:0]      tmr;
    logic [15:0]      phase;
    logic [15:0]      sw_f;
    logic [15:0]      dwell;
    logic [15:0]      pk;
    logic [15:0]      best_pk;
    logic [15:0]      best_f;
    logic             pos;
    logic [15:0]      cnt;
    logic [15:0]      win;
    logic [15:0]      cyc_pk;
    logic [15:0]      det_f;
    logic             det_new;
    logic [15:0]      res;
    logic             res_ok;
    logic             no_free;
    logic [15:0]      mon2;
  } nfb_state_t;
endpackage

// ### tb/nfb_panel.sv
// Purpose: Operator panel model on the drive's parameter port.
// Assumes: One-cycle strobes; read data stands the cycle after RD.
// Notes:   Signals move only by NBA just after a rising edge.
`timescale 1ns/1ps
module nfb_panel (
  input  wire logic        clk,   // Drive clock
  input  wire logic [15:0] rdata, // Read data
  output logic      [4:0]  addr,  // Parameter address
  output logic      [15:0] wdata, // Parameter value
  output logic             wr,    // Write strobe
  output logic             rd,    // Read strobe
  output logic             servo  // Servo enable
);
  initial begin
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    servo = 1'b0;
  end
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic set_servo(input logic on);
    @(posedge clk);
    servo <= on;
  endtask
  // Excitation is only allowed with the motor released
  task automatic start_sweep();
    set_servo(1'b0);
    wr_reg(5'h0d, 16'h0001);
  endtask
  // Two busy stages leave no room for a result, so move one away
  task automatic start_ident();
    logic [15:0] c;
    logic [15:0] f;
    rd_reg(5'h00, c);
    if (c[1:0] === 2'b11) begin
      rd_reg(5'h04, f);
      wr_reg(5'h07, f);
      wr_reg(5'h00, c & 16'hfffd);
    end
    wr_reg(5'h0d, 16'h0002);
  endtask
endmodule

// ### tb/testbench.sv
// Purpose: Self-checking bench for the notch filter bank.
// Assumes: One sample every two clocks; short identification time.
// Notes:   The long sweep is only checked at its start and abort.
`timescale 1ns/1ps
module testbench;
  localparam int unsigned ID_CYC = 12000;
  logic        clk, nrst, wr, rd, servo, tq_vld, tq_out_vld, ph;
  logic        sine_on, vib_on, chk_pass, chk_amp, meas, prev_vld, ce;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, tq_in, vib, tq_out, pk, amp, v;
  logic [31:0] gen_rs, tst_rs;
  int          smp, n_mismatch, n_tests, k;

  nfb_notch_bank #(.IDENT_CYCLES(ID_CYC)) uut (
    .CLK(clk), .NRST(nrst), .CE(ce), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .SERVO_ON(servo), .TQ_IN(tq_in),
    .TQ_IN_VALID(tq_vld), .VIB_IN(vib), .TQ_OUT(tq_out),
    .TQ_OUT_VALID(tq_out_vld));
  nfb_panel panel (.clk(clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .servo(servo));

  always #25 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] mag(input logic [15:0] x);
    return x[15] ? 16'(-x) : x;
  endfunction
  function automatic logic [15:0] clampv(input logic [15:0] x, lo, hi);
    return (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction
  // Frequency, width and depth fields repeat every three addresses
  function automatic logic [15:0] exp_clamp(input int f,
                                            input logic [15:0] x);
    if (f % 3 == 0) return clampv(x, 16'h0032, 16'h1388);
    if (f % 3 == 1) return clampv(x, 16'h0032, 16'h03e8);
    return clampv(x, 16'h0000, 16'h03e8);
  endfunction

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_range(input logic [15:0] got, lo, hi);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic chk_reg(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    panel.rd_reg(a, d);
    cmp_word(d, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pass_run();
    wait_cyc(8);
    chk_pass = 1'b1;
    wait_cyc(100);
    chk_pass = 1'b0;
  endtask
  task automatic peak(input logic [15:0] lo, hi);
    wait_cyc(800);
    pk = 16'h0000;
    meas = 1'b1;
    wait_cyc(400);
    meas = 1'b0;
    cmp_range(pk, lo, hi);
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Sample source: random or sine torque, square vibration of period 40
  always @(posedge clk) begin
    ph <= ~ph;
    tq_vld <= ph;
    if (ph) begin
      tq_in <= sine_on ? 16'($rtoi(8000.0 * $sin(6.2831853 * smp / 20.0)))
                       : gen_rs[15:0];
      vib <= !vib_on ? 16'h0000 : ((smp % 40 < 20) ? 16'h07d0 : 16'hf830);
      smp++;
      gen_rs = lfsr(gen_rs);
    end
  end

  always @(negedge clk) begin
    if (chk_pass) begin
      cmp_word(16'(tq_out_vld), 16'(prev_vld));
      if (tq_out_vld === 1'b1) cmp_word(tq_out, tq_in);
    end
    if (chk_amp && tq_out_vld === 1'b1) cmp_word(mag(tq_out), amp);
    if (meas && tq_out_vld === 1'b1 && mag(tq_out) > pk) pk = mag(tq_out);
    prev_vld = tq_vld;
  end

  initial begin
    wait_cyc(60000);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    {clk, nrst, ph, tq_vld, sine_on, vib_on} = 6'h00;
    {chk_pass, chk_amp, meas, prev_vld, ce} = 5'h01;
    {tq_in, vib, pk, amp, v} = 80'h0;
    {smp, n_mismatch, n_tests} = 0;
    gen_rs = 32'hd4f8725f;
    tst_rs = 32'hd4f8725f;
    wait_cyc(20);
    nrst <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      chk_reg(5'(1 + 3 * i), 16'h1388);
      chk_reg(5'(2 + 3 * i), 16'h0046);
      chk_reg(5'(3 + 3 * i), 16'h0000);
    end
    chk_reg(5'h00, 16'h0000);
    chk_reg(5'h0a, 16'h0064);
    chk_reg(5'h0c, 16'h03e8);
    chk_reg(5'h1f, 16'h0000);
    // Clock enable low must swallow a write
    @(posedge clk) ce <= 1'b0;
    panel.wr_reg(5'h0b, 16'h01f4);
    ce <= 1'b1;
    chk_reg(5'h0b, 16'h0064);
    // Boundary values first, then random values, all clamped to range
    for (int i = 0; i < 16; i++) begin
      tst_rs = lfsr(tst_rs);
      k = (i < 4) ? i : int'(tst_rs[31:16] % 9);
      v = (i < 4) ? ((i % 2) ? 16'h1389 : 16'h0031) : {3'h0, tst_rs[12:0]};
      panel.wr_reg(5'(k + 1), v);
      chk_reg(5'(k + 1), exp_clamp(k, v));
    end
    for (int i = 0; i < 3; i++) begin
      panel.wr_reg(5'(1 + 3 * i), 16'h1388);
      panel.wr_reg(5'(2 + 3 * i), 16'h0046);
      panel.wr_reg(5'(3 + 3 * i), 16'h0000);
    end
    pass_run();
    sine_on = 1'b1;
    panel.wr_reg(5'h01, 16'h03e8);
    pass_run();
    panel.wr_reg(5'h00, 16'h0001);
    peak(16'h0000, 16'h07d0);
    panel.wr_reg(5'h00, 16'h0000);
    panel.wr_reg(5'h07, 16'h03e8);
    peak(16'h0000, 16'h07d0);
    panel.wr_reg(5'h09, 16'h01f4);
    peak(16'h0bb8, 16'h1388);
    panel.wr_reg(5'h09, 16'h03e8);
    peak(16'h1770, 16'h2000);
    panel.wr_reg(5'h07, 16'h1388);
    pass_run();
    sine_on = 1'b0;
    panel.set_servo(1'b1);
    panel.wr_reg(5'h0d, 16'h0001);
    chk_reg(5'h0e, 16'h0000);
    panel.wr_reg(5'h0a, 16'h012c);
    amp = 16'h012c;
    panel.start_sweep();
    chk_reg(5'h0e, 16'h0001);
    wait_cyc(10);
    chk_amp = 1'b1;
    wait_cyc(400);
    chk_amp = 1'b0;
    panel.set_servo(1'b1);
    panel.rd_reg(5'h0e, v);
    cmp_word(v & 16'h0003, 16'h0000);
    panel.wr_reg(5'h0a, 16'h0000);
    chk_reg(5'h0a, 16'h0001);
    panel.wr_reg(5'h0c, 16'h1388);
    panel.wr_reg(5'h00, 16'h001c);
    vib_on = 1'b1;
    wait_cyc(12200);
    chk_reg(5'h01, 16'h03e8);
    panel.wr_reg(5'h0c, 16'h03e8);
    wait_cyc(12200);
    panel.rd_reg(5'h01, v);
    cmp_range(v, 16'h01e0, 16'h01fe);
    panel.rd_reg(5'h00, v);
    cmp_word(v & 16'h0001, 16'h0001);
    panel.wr_reg(5'h00, 16'h0003);
    panel.start_ident();
    panel.rd_reg(5'h0e, v);
    cmp_word(v & 16'h0003, 16'h0002);
    wait_cyc(ID_CYC - 300);
    panel.rd_reg(5'h0e, v);
    cmp_word(v & 16'h0003, 16'h0002);
    wait_cyc(400);
    panel.rd_reg(5'h0e, v);
    cmp_word(v & 16'h000b, 16'h0008);
    panel.rd_reg(5'h0f, v);
    cmp_range(v, 16'h01e0, 16'h01fe);
    panel.wr_reg(5'h0d, 16'h0004);
    panel.rd_reg(5'h00, v);
    cmp_word(v & 16'h0003, 16'h0003);
    panel.rd_reg(5'h04, v);
    cmp_range(v, 16'h01e0, 16'h01fe);
    panel.wr_reg(5'h0d, 16'h0004);
    panel.rd_reg(5'h0e, v);
    cmp_word(v & 16'h0004, 16'h0004);
    panel.wr_reg(5'h0d, 16'h0002);
    panel.wr_reg(5'h0d, 16'h0008);
    panel.rd_reg(5'h0e, v);
    cmp_word(v & 16'h0003, 16'h0000);
    end_of_test();
  end
endmodule
